// File: inc/rsa_defs.vh
// What this block does
// - return pops the stack and loads stack_top into the program counter; flags unchanged
// - return takes two instruction cycles
// - sleep clears watchdog_counter and its prescaler to zero
// - sleep clears sleep_entry_flag, sets watchdog_expiry_bit, touches no other status bit
// - after sleep the core enters low-power sleep with oscillator halted
// - sub_literal: immediate minus accumulator into accumulator; updates borrow, nibble, zero flags
// - sub_from_register: register minus accumulator, routed by target bit; updates three flags
// - xor_literal: accumulator xor immediate into accumulator; only zero flag changes
// - xor_register: accumulator xor register, routed by target bit; only zero flag changes
// - nibble_swap exchanges register nibbles into destination; no flag changes
// - target bit 0 writes accumulator, 1 writes back the 7-bit addressed register
`ifndef RSA_DEFS_VH
`define RSA_DEFS_VH
`define RSA_OP_NONE 3'h0
`define RSA_OP_RETURN 3'h1
`define RSA_OP_SLEEP 3'h2
`define RSA_OP_SUBL 3'h3
`define RSA_OP_SUBF 3'h4
`define RSA_OP_XORL 3'h5
`define RSA_OP_XORF 3'h6
`define RSA_OP_NIBBLE_SWAP 3'h7
`define RSA_ACC_RST 8'h00
`define RSA_PC_RST 13'h0000
`define RSA_WDT_CLR 8'h00
`define RSA_PRE_CLR 8'h00
`define RSA_ST_C 0
`define RSA_ST_DC 1
`define RSA_ST_Z 2
`define RSA_ST_PD 3
`define RSA_ST_TO 4
`define RSA_STATUS_RST 5'h18
`define RSA_STACK_DEPTH 8
`endif

// File: rtl/rsa_alu.v
`timescale 1ns/1ns
`include "rsa_defs.vh"
module rsa_alu (
	input wire [2:0] op_i,        // operation code
	input wire [7:0] acc_i,       // accumulator
	input wire [7:0] lit_i,       // immediate byte
	input wire [7:0] reg_i,       // addressed register value
	output reg [7:0] res_o,       // result
	output reg c_o,               // no borrow out of bit 7
	output reg dc_o,              // no borrow out of bit 3
	output reg z_o                // result zero
);
	reg [8:0] diff;
	reg [4:0] ndiff;
	reg [7:0] minu;
	always @* begin
		minu = (op_i == `RSA_OP_SUBL) ? lit_i : reg_i;
		diff = {1'b0, minu} + {1'b0, ~acc_i} + 9'h001;
		ndiff = {1'b0, minu[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
		c_o = diff[8];
		dc_o = ndiff[4];
		case (op_i)
			`RSA_OP_SUBL, `RSA_OP_SUBF: res_o = diff[7:0];
			`RSA_OP_XORL: res_o = acc_i ^ lit_i;
			`RSA_OP_XORF: res_o = acc_i ^ reg_i;
			`RSA_OP_NIBBLE_SWAP: res_o = {reg_i[3:0], reg_i[7:4]};
			default: res_o = 8'h00;
		endcase
		z_o = (res_o == 8'h00);
	end
endmodule // rsa_alu

// File: rtl/rsa_core.v
`timescale 1ns/1ns
`include "rsa_defs.vh"
module rsa_core (
	input wire core_clk_i,          // instruction clock
	input wire reset_n_i,           // async reset, active low
	input wire instr_valid_i,       // decoded instruction present
	input wire [2:0] instr_op_i,    // operation code
	input wire [7:0] immediate_byte_i, // literal operand
	input wire [6:0] register_operand_i, // file register address
	input wire result_target_bit_i, // 0 accumulator, 1 register
	input wire [7:0] reg_rdata_i,   // addressed register value
	input wire [12:0] stack_top_i,  // return address on stack top
	input wire wake_i,              // wake event from sleep
	output reg instr_ready_o,       // core accepts an instruction
	output reg [7:0] accumulator_o, // accumulator
	output reg reg_we_o,            // register file write strobe
	output reg [6:0] reg_waddr_o,   // register file write address
	output reg [7:0] reg_wdata_o,   // register file write data
	output reg stack_pop_o,         // stack pop strobe
	output reg [12:0] pc_o,         // program counter
	output reg [7:0] watchdog_counter_o, // watchdog count
	output reg [7:0] prescaler_o,   // watchdog prescaler
	output reg [4:0] status_o,      // to,pd,z,dc,c
	output reg osc_halt_o           // oscillator stopped, sleep state
);
	localparam ST_RUN = 2'h0;
	localparam ST_RET2 = 2'h1;
	localparam ST_SLEEP = 2'h2;

	function op_is_ret;
		input [2:0] op;
		begin
			op_is_ret = (op == `RSA_OP_RETURN);
		end
	endfunction

	function op_is_sleep;
		input [2:0] op;
		begin
			op_is_sleep = (op == `RSA_OP_SLEEP);
		end
	endfunction

	function op_is_sub;
		input [2:0] op;
		begin
			op_is_sub = (op == `RSA_OP_SUBL) || (op == `RSA_OP_SUBF);
		end
	endfunction

	function op_is_xor;
		input [2:0] op;
		begin
			op_is_xor = (op == `RSA_OP_XORL) || (op == `RSA_OP_XORF);
		end
	endfunction

	// literal forms always land in the accumulator; no target bit applies
	function op_is_lit;
		input [2:0] op;
		begin
			op_is_lit = (op == `RSA_OP_SUBL) || (op == `RSA_OP_XORL);
		end
	endfunction

	function op_is_file;
		input [2:0] op;
		begin
			op_is_file = (op == `RSA_OP_SUBF) || (op == `RSA_OP_XORF) ||
				(op == `RSA_OP_NIBBLE_SWAP);
		end
	endfunction

	function op_sets_zero;
		input [2:0] op;
		begin
			op_sets_zero = op_is_sub(op) || op_is_xor(op);
		end
	endfunction

	function [12:0] pc_step;
		input [12:0] pc;
		begin
			pc_step = pc + 13'h0001;
		end
	endfunction

	function [4:0] sleep_status;
		input [4:0] st;
		reg [4:0] tmp;
		begin
			tmp = st;
			tmp[`RSA_ST_PD] = 1'b0;
			tmp[`RSA_ST_TO] = 1'b1;
			sleep_status = tmp;
		end
	endfunction

	reg ready_nxt;
	reg [7:0] acc_nxt;
	reg we_nxt;
	reg [6:0] waddr_nxt;
	reg [7:0] wdata_nxt;
	reg pop_nxt;
	reg [12:0] pc_nxt;
	reg [7:0] wdt_nxt;
	reg [7:0] pre_nxt;
	reg [4:0] status_nxt;
	reg halt_nxt;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg wake_s1_r;
	reg wake_s2_r;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;
	wire take;
	assign take = instr_valid_i && instr_ready_o;
	rsa_alu u_alu (
		.op_i(instr_op_i),
		.acc_i(accumulator_o),
		.lit_i(immediate_byte_i),
		.reg_i(reg_rdata_i),
		.res_o(alu_res),
		.c_o(alu_c),
		.dc_o(alu_dc),
		.z_o(alu_z)
	);
	// wake is an asynchronous pin: two stages before use
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_s1_r <= 1'b0;
			wake_s2_r <= 1'b0;
		end else begin
			wake_s1_r <= wake_i;
			wake_s2_r <= wake_s1_r;
		end
	end

	wire take_ret;
	wire take_sleep;
	wire take_lit;
	wire take_file;
	wire file_to_reg;
	wire file_to_acc;
	wire take_sub;
	wire take_zero;
	assign take_ret = take && op_is_ret(instr_op_i);
	assign take_sleep = take && op_is_sleep(instr_op_i);
	assign take_lit = take && op_is_lit(instr_op_i);
	assign take_file = take && op_is_file(instr_op_i);
	assign file_to_reg = take_file && result_target_bit_i;
	assign file_to_acc = take_file && !result_target_bit_i;
	assign take_sub = take && op_is_sub(instr_op_i);
	assign take_zero = take && op_sets_zero(instr_op_i);

	// return and sleep are the only ops that hold the core out of the run state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (take_ret) begin
					state_nxt = ST_RET2;
				end else if (take_sleep) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_RET2: begin
				state_nxt = ST_RUN;
			end
			ST_SLEEP: begin
				// level wake: a wake still high when sleep is taken ends it at once
				if (wake_s2_r) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always @* begin
		ready_nxt = (state_nxt == ST_RUN);
		halt_nxt = (state_nxt == ST_SLEEP);
	end

	always @* begin
		pc_nxt = pc_o;
		pop_nxt = 1'b0;
		if (take_ret) begin
			pop_nxt = 1'b1;
			pc_nxt = stack_top_i;
		end else if (take) begin
			pc_nxt = pc_step(pc_o);
		end
	end

	// this block holds no count of its own; only the clear on sleep lives here
	always @* begin
		wdt_nxt = watchdog_counter_o;
		pre_nxt = prescaler_o;
		if (take_sleep) begin
			wdt_nxt = `RSA_WDT_CLR;
			pre_nxt = `RSA_PRE_CLR;
		end
	end

	always @* begin
		acc_nxt = accumulator_o;
		if (take_lit) begin
			acc_nxt = alu_res;
		end else if (file_to_acc) begin
			acc_nxt = alu_res;
		end
	end

	// address and data hold their last value; only the strobe is a pulse
	always @* begin
		we_nxt = 1'b0;
		waddr_nxt = reg_waddr_o;
		wdata_nxt = reg_wdata_o;
		if (file_to_reg) begin
			we_nxt = 1'b1;
			waddr_nxt = register_operand_i;
			wdata_nxt = alu_res;
		end
	end

	// return and swap fall through here untouched, so their flags stay put
	always @* begin
		status_nxt = status_o;
		if (take_sleep) begin
			status_nxt = sleep_status(status_o);
		end
		if (take_sub) begin
			status_nxt[`RSA_ST_C] = alu_c;
			status_nxt[`RSA_ST_DC] = alu_dc;
		end
		if (take_zero) begin
			status_nxt[`RSA_ST_Z] = alu_z;
		end
	end

	// every output is a flop fed only by the next values above
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			instr_ready_o <= 1'b0;
			osc_halt_o <= 1'b0;
		end else begin
			instr_ready_o <= ready_nxt;
			osc_halt_o <= halt_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_o <= `RSA_PC_RST;
			stack_pop_o <= 1'b0;
		end else begin
			pc_o <= pc_nxt;
			stack_pop_o <= pop_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			watchdog_counter_o <= `RSA_WDT_CLR;
			prescaler_o <= `RSA_PRE_CLR;
		end else begin
			watchdog_counter_o <= wdt_nxt;
			prescaler_o <= pre_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			accumulator_o <= `RSA_ACC_RST;
		end else begin
			accumulator_o <= acc_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_we_o <= 1'b0;
			reg_waddr_o <= 7'h00;
			reg_wdata_o <= 8'h00;
		end else begin
			reg_we_o <= we_nxt;
			reg_waddr_o <= waddr_nxt;
			reg_wdata_o <= wdata_nxt;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_o <= `RSA_STATUS_RST;
		end else begin
			status_o <= status_nxt;
		end
	end
endmodule // rsa_core

// File: verif/rsa_chk.sv
`timescale 1ns/1ns
module rsa_chk (
	input wire core_clk_i, // clk
	input wire reset_n_i, // rst
	input wire instr_valid_i, // valid
	input wire [2:0] instr_op_i, // op
	input wire [6:0] register_operand_i, // addr
	input wire result_target_bit_i, // dest
	input wire [12:0] stack_top_i, // tos
	input wire [7:0] immediate_byte_i, // imm
	input wire instr_ready_o, // ready
	input wire [7:0] accumulator_o, // acc
	input wire reg_we_o, // write
	input wire [6:0] reg_waddr_o, // waddr
	input wire stack_pop_o, // pop
	input wire [12:0] pc_o, // pc
	input wire [7:0] watchdog_counter_o, // wdt
	input wire [7:0] prescaler_o, // pre
	input wire [4:0] status_o, // flags
	input wire osc_halt_o // halt
);
	wire tk = instr_valid_i && instr_ready_o;
	wire [2:0] op = instr_op_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_ret_pop: assert property (tk && op == 3'h1 |=> stack_pop_o &&
		pc_o == $past(stack_top_i) && $stable(status_o)) else $error("return pop");
	a_ret_stall: assert property (tk && op == 3'h1 |=> !instr_ready_o ##1 instr_ready_o)
		else $error("return length");
	a_slp_clear: assert property (tk && op == 3'h2 |=> watchdog_counter_o == 8'h00 &&
		prescaler_o == 8'h00) else $error("sleep clear");
	a_slp_flags: assert property (tk && op == 3'h2 |=>
		status_o == ($past(status_o) & 5'h07 | 5'h10)) else $error("sleep flags");
	a_slp_halt: assert property (tk && op == 3'h2 |=> osc_halt_o && !instr_ready_o)
		else $error("sleep halt");
	a_xor_flags: assert property (tk && (op == 3'h5 || op == 3'h6) |=>
		((status_o ^ $past(status_o)) & 5'h1B) == 5'h00) else $error("xor flags");
	a_swap_keep: assert property (tk && op == 3'h7 |=> $stable(status_o))
		else $error("swap flags");
	a_reg_dest: assert property (tk && (op == 3'h4 || op >= 3'h6) && result_target_bit_i
		|=> reg_we_o && reg_waddr_o == $past(register_operand_i)) else $error("reg dest");
	a_acc_dest: assert property (tk && op >= 3'h3 && !result_target_bit_i |=> !reg_we_o)
		else $error("acc dest");
	a_subl_math: assert property (tk && op == 3'h3 |=>
		accumulator_o == $past(immediate_byte_i) - $past(accumulator_o) &&
		status_o[0] == ($past(immediate_byte_i) >= $past(accumulator_o)) &&
		status_o[2] == (accumulator_o == 8'h00)) else $error("sub literal");
	c_ret: cover property (tk && op == 3'h1);
	c_slp: cover property (tk && op == 3'h2);
	c_wr: cover property (reg_we_o);
	c_wake: cover property ($fell(osc_halt_o));
endmodule // rsa_chk
bind rsa_core rsa_chk chk_u (.core_clk_i, .reset_n_i, .instr_valid_i, .instr_op_i,
	.register_operand_i, .result_target_bit_i, .stack_top_i, .instr_ready_o, .reg_we_o,
	.reg_waddr_o, .stack_pop_o, .pc_o, .watchdog_counter_o, .prescaler_o, .status_o,
	.osc_halt_o, .immediate_byte_i, .accumulator_o);

// File: verif/return_sleep_alu_op_subset_tb.sv
`timescale 1ns/1ns
module return_sleep_alu_op_subset_tb;
	logic clk = 0, rst_n = 0, vld = 0, tgt = 0, wake = 0;
	logic [2:0] op = 0;
	logic [7:0] imm = 0, rd = 0;
	logic [6:0] adr = 0;
	logic [12:0] stack_top = 0;
	wire rdy, we, pop, halt;
	wire [7:0] acc, wd, wdt, pre;
	wire [6:0] wa;
	wire [12:0] pc;
	wire [4:0] st;
	int bad_count = 0, compares = 0, m_acc = 0, m_st = 'h18, m_pc = 0, i;
	rsa_core dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .instr_valid_i(vld), .instr_op_i(op),
		.immediate_byte_i(imm), .register_operand_i(adr), .result_target_bit_i(tgt),
		.reg_rdata_i(rd), .stack_top_i(stack_top), .wake_i(wake), .instr_ready_o(rdy),
		.accumulator_o(acc), .reg_we_o(we), .reg_waddr_o(wa), .reg_wdata_o(wd),
		.stack_pop_o(pop), .pc_o(pc), .watchdog_counter_o(wdt), .prescaler_o(pre),
		.status_o(st), .osc_halt_o(halt));
	initial forever #2 clk = ~clk;
	task end_of_test;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(string n, logic [15:0] e, logic [15:0] s);
		compares++;
		if (e !== s) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task wait_rdy;
		for (i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk);
		if (rdy !== 1'b1) begin
			bad_count++;
			end_of_test;
		end
	endtask
	task run(input [2:0] o);
		logic [7:0] x;
		int v;
		logic w;
		wait_rdy;
		op = o; imm = $urandom; rd = $urandom; adr = $urandom; tgt = $urandom; stack_top = $urandom;
		// valid stays up into the next call, so a refused cycle must not take it twice
		vld = 1;
		@(negedge clk);
		x = m_acc;
		w = 0;
		case (o)
			3, 4: begin
				v = (o == 3) ? imm : rd;
				x = v - m_acc;
				m_st[0] = v >= m_acc;
				m_st[1] = v % 16 >= m_acc % 16;
			end
			5: x = imm ^ m_acc;
			6: x = rd ^ m_acc;
			7: x = {rd[3:0], rd[7:4]};
			2: m_st = m_st & 7 | 16;
		endcase
		if (o >= 3 && o <= 6) m_st[2] = x == 0;
		if (o >= 4 && o != 5 && tgt) w = 1;
		else if (o >= 3) m_acc = x;
		m_pc = (o == 1) ? stack_top : (m_pc + 1) % 8192;
		chk("acc", m_acc, acc);
		chk("status", m_st, st);
		chk("pc", m_pc, pc);
		chk("pop", o == 1, pop);
		chk("ready", o < 1 || o > 2, rdy);
		chk("we", w, we);
		if (w) chk("wr", {adr, x}, {wa, wd});
		if (o == 2) begin
			chk("wdt", 0, {wdt, pre});
			chk("halt", 1, halt);
			// ready only returns after the wake synchroniser, so hold wake until then
			vld = 0;
			wake = 1;
			wait_rdy;
			wake = 0;
			chk("halt", 0, halt);
		end
	endtask
	initial begin
		i = $urandom(64675);
		repeat (20) @(negedge clk);
		rst_n = 1;
		for (int n = 0; n < 240; n++) begin
			if (n == 120) begin
				vld = 0;
				rst_n = 0;
				@(negedge clk);
				chk("rst acc", 0, acc);
				chk("rst status", 'h18, st);
				chk("rst pc", 0, pc);
				chk("rst ready", 0, rdy);
				rst_n = 1;
				m_acc = 0;
				m_st = 'h18;
				m_pc = 0;
			end
			run(n % 8);
		end
		end_of_test;
	end
endmodule // return_sleep_alu_op_subset_tb
